// ===== src/cmd_queue.v
// in-order command queue of four entries, registered read data
// assumes commands arrive on the same clock as the main block
`timescale 1ns/1ps
module cmd_queue (
  input wire clk,
  input wire resetn,
  input wire wr_valid,
  input wire [1:0] wr_cmd,
  input wire rd_take,
  output reg rd_valid,
  output reg [1:0] rd_cmd,
  output wire full
);
  reg [1:0] mem [0:3];
  reg [2:0] wp_q;
  reg [2:0] rp_q;
  wire empty = (wp_q == rp_q);
  wire pop = (~rd_valid | rd_take) & ~empty;
  assign full = (wp_q[1:0] == rp_q[1:0]) & (wp_q[2] != rp_q[2]);
  always @(posedge clk) begin
    if (wr_valid & ~full) begin
      mem[wp_q[1:0]] <= wr_cmd;
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      rd_valid <= 1'b0;
      rd_cmd <= 2'h0;
    end else begin
      if (wr_valid & ~full) begin
        wp_q <= wp_q + 3'h1;
      end
      if (pop) begin
        rp_q <= rp_q + 3'h1;
        rd_cmd <= mem[rp_q[1:0]];
        rd_valid <= 1'b1;
      end else if (rd_take) begin
        rd_valid <= 1'b0;
      end
    end
  end
endmodule

// ===== src/trigger_source_select.v
// trigger source selection and qualification
// assumes ext_trig_pin is asynchronous, all other inputs on clk
// Operation
// - the source setting holds free-run, external or bus and is readable as a code.
// - free-run triggers itself as soon as the measurement is armed.
// - external source triggers on a falling edge of the trigger pin.
// - bus source triggers on the common, immediate or group execute trigger.
// - external and bus triggers are taken only while waiting, else dropped.
// - status bit 5 is registered from waiting, so it follows waiting one clock later.
// - the selection routes either the pin or the bus events into the trigger path.
// - group execute trigger acts at once; trigger commands go through the queue in order.
`timescale 1ns/1ps
`include "trigger_source_select_regs.vh"
module trigger_source_select (
  input wire clk,
  input wire resetn,
  input wire preset,
  input wire src_wr,
  input wire [1:0] src_wdata,
  input wire armed,
  input wire waiting,
  input wire ext_trig_pin,
  input wire group_exec_trig,
  input wire cmd_valid,
  input wire [1:0] cmd_code,
  output reg cmd_ready,
  output reg [1:0] src_sel,
  output reg [15:0] oper_cond,
  output reg trig_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ARMED = 2'b10;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_s3_q;
  reg [1:0] src_sel_d;
  reg src_ok;
  reg sel_free;
  reg sel_ext;
  reg sel_bus;
  reg cmd_is_trig;
  reg path_trig;
  reg arm_entry;
  reg trig_d;
  wire q_valid;
  wire [1:0] q_cmd;
  wire q_full;
  wire ext_fall;
  wire bus_cmd_trig;
  wire bus_trig;
  wire cmd_ready_d;
  wire [15:0] oper_cond_d;
  genvar b;

  // in-order queue for trigger commands
  cmd_queue u_queue (
    .clk(clk),
    .resetn(resetn),
    .wr_valid(cmd_valid),
    .wr_cmd(cmd_code),
    .rd_take(q_valid),
    .rd_valid(q_valid),
    .rd_cmd(q_cmd),
    .full(q_full)
  );

  // pin synchroniser, reset to idle high
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_s1_q <= `PIN_IDLE;
      ext_s2_q <= `PIN_IDLE;
      ext_s3_q <= `PIN_IDLE;
    end else begin
      ext_s1_q <= ext_trig_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_fall = ext_s3_q & ~ext_s2_q;

  // legal source codes
  always @* begin
    src_ok = 1'b0;
    case (src_wdata)
      `SRC_FREE_RUN: src_ok = 1'b1;
      `SRC_EXTERNAL: src_ok = 1'b1;
      `SRC_BUS: src_ok = 1'b1;
      default: src_ok = 1'b0;
    endcase
  end

  // preset beats a write
  always @* begin
    src_sel_d = src_sel;
    if (preset) begin
      src_sel_d = `SRC_RESET;
    end else if (src_wr && src_ok) begin
      src_sel_d = src_wdata;
    end
  end

  // source decode
  always @* begin
    sel_free = 1'b0;
    sel_ext = 1'b0;
    sel_bus = 1'b0;
    case (src_sel)
      `SRC_FREE_RUN: sel_free = 1'b1;
      `SRC_EXTERNAL: sel_ext = 1'b1;
      `SRC_BUS: sel_bus = 1'b1;
      default: sel_free = 1'b0;
    endcase
  end

  // queued command decode
  always @* begin
    cmd_is_trig = 1'b0;
    case (q_cmd)
      `CMD_COMMON_TRIG: cmd_is_trig = 1'b1;
      `CMD_IMM_TRIG: cmd_is_trig = 1'b1;
      default: cmd_is_trig = 1'b0;
    endcase
  end

  assign bus_cmd_trig = q_valid & cmd_is_trig;
  assign bus_trig = group_exec_trig | bus_cmd_trig;

  // trigger routing
  always @* begin
    path_trig = 1'b0;
    if (sel_ext) begin
      path_trig = ext_fall;
    end else if (sel_bus) begin
      path_trig = bus_trig;
    end
  end

  // arm tracking
  always @* begin
    state_d = state_q;
    arm_entry = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (armed) begin
          state_d = ST_ARMED;
          arm_entry = 1'b1;
        end
      end
      ST_ARMED: begin
        if (!armed) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // free-run fires once on entry to armed
  always @* begin
    trig_d = 1'b0;
    if (sel_free) begin
      trig_d = arm_entry;
    end else begin
      trig_d = path_trig & waiting;
    end
  end

  // status word, only the waiting bit live
  generate
    for (b = 0; b < `OPER_W; b = b + 1) begin : g_oper
      if (b == `OPER_WAIT_BIT) begin : g_wait
        assign oper_cond_d[b] = waiting;
      end else begin : g_zero
        assign oper_cond_d[b] = 1'b0;
      end
    end
  endgenerate

  assign cmd_ready_d = ~q_full;

  // output and arm state registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_sel <= `SRC_RESET;
    end else begin
      src_sel <= src_sel_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_out <= 1'b0;
    end else begin
      trig_out <= trig_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oper_cond <= `OPER_RESET;
    end else begin
      oper_cond <= oper_cond_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= cmd_ready_d;
    end
  end
endmodule

// ===== src/trigger_source_select_regs.vh
// constants for the trigger source selection block
// assumes inclusion by bare name from the design files
`ifndef TRIGGER_SOURCE_SELECT_REGS_VH
`define TRIGGER_SOURCE_SELECT_REGS_VH
`define SRC_W 2
`define SRC_FREE_RUN 2'h0
`define SRC_EXTERNAL 2'h1
`define SRC_BUS 2'h2
`define SRC_RESET 2'h0
`define PIN_IDLE 1'b1
`define OPER_RESET 16'h0000
`define CMD_W 2
`define CMD_COMMON_TRIG 2'h0
`define CMD_IMM_TRIG 2'h1
`define CMD_OTHER 2'h2
`define OPER_W 16
`define OPER_WAIT_BIT 5
`endif

// ===== verif/trigger_source_select_tb.sv
// bench for the trigger selector
// needs tss_far and tss_chk
`timescale 1ns/1ps
module trigger_source_select_tb;
  reg clk = 0, resetn = 0, preset = 0, src_wr = 0, armed = 0, waiting = 0;
  reg [1:0] src_wdata = 0, s, k;
  wire ext_trig_pin, group_exec_trig, cmd_valid, cmd_ready, trig_out;
  wire [1:0] cmd_code, src_sel;
  wire [15:0] oper_cond;
  integer num_errors = 0, total_checks = 0, hits = 0, i;
  always #5 clk = ~clk;
  always @(posedge clk) hits = hits + (trig_out === 1'b1);
  tss_far far (
    .clk(clk),
    .ext_trig_pin(ext_trig_pin),
    .group_exec_trig(group_exec_trig),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code)
  );
  trigger_source_select dut (
    .clk(clk),
    .resetn(resetn),
    .preset(preset),
    .src_wr(src_wr),
    .src_wdata(src_wdata),
    .armed(armed),
    .waiting(waiting),
    .ext_trig_pin(ext_trig_pin),
    .group_exec_trig(group_exec_trig),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .cmd_ready(cmd_ready),
    .src_sel(src_sel),
    .oper_cond(oper_cond),
    .trig_out(trig_out)
  );
  task chk(input string n, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("BAD %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  function [15:0] want(input [1:0] q, input w, input [1:0] c);
    want = q == 2'h0 || (w && !(q == 2'h2 && c == 2'h3));
  endfunction
  task wr(input [1:0] v, input p);
    begin
      @(posedge clk);
      src_wr <= 1'b1;
      preset <= p;
      src_wdata <= v;
      @(posedge clk);
      {src_wr, preset} <= 2'h0;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  initial begin
    s = $urandom(32'h2158f29e);
    repeat (20) @(posedge clk);
    resetn <= 1;
    for (i = 0; i < 24; i = i + 1) begin
      s = i < 15 ? i % 3 : $urandom % 3;
      k = i < 12 ? i / 3 : (i < 15 ? 2'h2 : $urandom % 4);
      @(posedge clk);
      waiting <= i < 12 || (i >= 15 && $urandom % 2);
      armed <= 0;
      wr(s, 0);
      hits = 0;
      @(posedge clk);
      armed <= s == 2'h0;
      far.send(k);
      repeat (8) @(posedge clk);
      #1;
      chk("sel", s, src_sel);
      chk("trig", want(s, waiting, k), hits);
      chk("wait", {waiting, 5'h00}, oper_cond);
      $display("test %0d done", i);
    end
    wr(2'h3, 0);
    chk("keep", s, src_sel);
    $display("test keep done");
    wr(2'h1, 1);
    chk("preset", 2'h0, src_sel);
    $display("test preset done");
    wr(2'h2, 0);
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    chk("reset sel", 2'h0, src_sel);
    chk("reset ready", 1'b0, cmd_ready);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("ready", 1'b1, cmd_ready);
    $display("test reset done");
    wrap_up;
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    wrap_up;
  end
endmodule
bind trigger_source_select tss_chk u_chk (
  .clk(clk),
  .resetn(resetn),
  .preset(preset),
  .src_wr(src_wr),
  .src_wdata(src_wdata),
  .armed(armed),
  .waiting(waiting),
  .ext_trig_pin(ext_trig_pin),
  .group_exec_trig(group_exec_trig),
  .src_sel(src_sel),
  .oper_cond(oper_cond),
  .trig_out(trig_out)
);

// ===== verif/tss_chk.sv
// port checker for the trigger selector
// bound to the top by the bench
`timescale 1ns/1ps
module tss_chk (
  input wire clk,
  input wire resetn,
  input wire preset,
  input wire src_wr,
  input wire [1:0] src_wdata,
  input wire armed,
  input wire waiting,
  input wire ext_trig_pin,
  input wire group_exec_trig,
  input wire [1:0] src_sel,
  input wire [15:0] oper_cond,
  input wire trig_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_wt; 1'b1 |=> oper_cond == {10'h000, $past(waiting), 5'h00}; endproperty
  a_wt: assert property (p_wt) else $error("bad wait bit");
  property p_sl; src_wr && !preset && src_wdata != 2'h3 |=> src_sel == $past(src_wdata);
  endproperty
  a_sl: assert property (p_sl) else $error("bad sel");
  property p_ps; preset |=> src_sel == 2'h0; endproperty
  a_ps: assert property (p_ps) else $error("bad preset");
  property p_fr; $rose(armed) && src_sel == 2'h0 |=> trig_out; endproperty
  a_fr: assert property (p_fr) else $error("bad free run");
  property p_gt; group_exec_trig && waiting && src_sel == 2'h2 |=> trig_out; endproperty
  a_gt: assert property (p_gt) else $error("bad get");
  property p_ex; $fell(ext_trig_pin) && waiting && src_sel == 2'h1 |-> ##[1:5] trig_out;
  endproperty
  a_ex: assert property (p_ex) else $error("bad ext");
  property p_dr; (!waiting && src_sel != 2'h0) [*5] |=> !trig_out; endproperty
  a_dr: assert property (p_dr) else $error("bad drop");
  c_gt: cover property (group_exec_trig && waiting);
  c_ex: cover property ($fell(ext_trig_pin) && waiting);
  c_sl: cover property (src_wr);
  c_fr: cover property ($rose(armed) && src_sel == 2'h0);
endmodule

// ===== verif/tss_far.sv
// far side: bus controller and ttl trigger source
// driven by bench task calls
`timescale 1ns/1ps
module tss_far (
  input wire clk,
  output reg ext_trig_pin,
  output reg group_exec_trig,
  output reg cmd_valid,
  output reg [1:0] cmd_code
);
  initial begin
    ext_trig_pin = 1'b1;
    group_exec_trig = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 2'h2;
  end
  // pin edge and one bus event every call, whatever the source
  // k: 0 common, 1 immediate, 2 group execute, 3 other command
  task send(input [1:0] k);
    begin
      @(posedge clk);
      ext_trig_pin <= 1'b0;
      group_exec_trig <= k == 2'h2;
      cmd_valid <= k != 2'h2;
      cmd_code <= k == 2'h3 ? 2'h2 : k;
      @(posedge clk);
      ext_trig_pin <= 1'b1;
      group_exec_trig <= 1'b0;
      cmd_valid <= 1'b0;
    end
  endtask
endmodule
